// [design/fbh_pkg.sv]
// package for the fetch byte handshake command port
package fbh_pkg;
  localparam int unsigned FBH_BYTE_W = 8;
  localparam int unsigned FBH_ADDR_W = 32;
  localparam int unsigned FBH_CNT_W = 16;
  localparam int unsigned FBH_CMD_BYTES = 6;
  localparam int unsigned FBH_RESET_READS = 2;
  localparam int unsigned FBH_FIFO_DEPTH = 16;
  localparam logic [2:0] FBH_IDX_W = 3'h3;
  localparam logic [7:0] FBH_BYTE_RST = 8'h00;

  typedef struct packed {
    logic [FBH_ADDR_W-1:0] addr;
    logic [FBH_CNT_W-1:0] fetch_byte_count;
  } fbh_cmd_t;

  typedef struct packed {
    logic full;
    logic empty;
    logic [FBH_BYTE_W-1:0] rx_data;
  } fbh_link_in_t;

  typedef enum logic [2:0] {
    FBH_ST_PURGE = 3'b000,
    FBH_ST_RSTRD = 3'b001,
    FBH_ST_IDLE = 3'b011,
    FBH_ST_SEND = 3'b010,
    FBH_ST_RECV = 3'b110
  } fbh_state_t;
endpackage : fbh_pkg

// [design/fbh_fifo.sv]
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module fbh_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic do_wr, do_rd;

  always_comb begin
    do_wr = wr_valid_in && (cnt_reg != AW'(0) + (AW+1)'(DEPTH));
    do_rd = rd_ready_in && (cnt_reg != '0);
    wp_next = do_wr ? ((wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1) : wp_reg;
    rp_next = do_rd ? ((rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1) : rp_reg;
    cnt_next = cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
    end
    if (do_wr) begin
      mem_reg[wp_reg] <= wr_data_in;
    end
  end

  assign wr_ready_out = (cnt_reg != (AW+1)'(DEPTH));
  assign rd_valid_out = (cnt_reg != '0);
  assign rd_data_out = mem_reg[rp_reg];
endmodule : fbh_fifo
`default_nettype wire

// [design/fbh_fetch_port.sv]
// fetch port: reset reads, six-byte command, response collection into a fifo
`timescale 1ns/1ps
`default_nettype none
module fbh_fetch_port
  import fbh_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = FBH_FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic srst_in,
  // fetch request from the user side
  input wire fbh_cmd_t cmd_in,
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  // fetched bytes and the init done flag to the user side
  output logic [FBH_BYTE_W-1:0] data_out,
  output logic data_valid_out,
  input wire logic data_ready_in,
  output logic init_done_out,
  // link to the peripheral
  input wire logic fetch_txfull_in,
  output logic [FBH_BYTE_W-1:0] fetch_txdata_out,
  output logic fetch_txwrite_out,
  input wire logic fetch_rxempty_in,
  input wire logic [FBH_BYTE_W-1:0] fetch_rxdata_in,
  output logic fetch_rxread_out
);
  fbh_state_t state_reg, state_next;
  fbh_cmd_t cmd_reg, cmd_next;
  logic [FBH_IDX_W-1:0] idx_reg, idx_next;
  logic [FBH_CNT_W-1:0] left_reg, left_next;
  logic [FBH_BYTE_W-1:0] txd_reg, txd_next;
  logic txw_reg, txw_next;
  logic rxr_reg, rxr_next;
  logic cmd_rdy_reg, cmd_rdy_next;
  logic init_reg, init_next;
  logic [FBH_BYTE_W-1:0] fifo_d_reg, fifo_d_next;
  logic fifo_v_reg, fifo_v_next;
  logic fifo_wr_ready;
  logic [FBH_BYTE_W-1:0] fo_data;
  logic fo_valid;
  logic [FBH_BYTE_W-1:0] dout_reg, dout_next;
  logic dv_reg, dv_next;
  logic fo_pop;
  logic [FBH_CMD_BYTES*FBH_BYTE_W-1:0] cmd_bytes;
  logic [FBH_BYTE_W-1:0] cur_byte;
  logic room;

  ////////////////////////////////////////////////////////////////////////////
  // response buffer
  fbh_fifo #(
    .WIDTH(FBH_BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .wr_data_in(fifo_d_reg),
    .wr_valid_in(fifo_v_reg),
    .wr_ready_out(fifo_wr_ready),
    .rd_data_out(fo_data),
    .rd_valid_out(fo_valid),
    .rd_ready_in(fo_pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // output register stage
  always_comb begin
    fo_pop = fo_valid && (!dv_reg || data_ready_in);
    dv_next = dv_reg;
    dout_next = dout_reg;
    if (dv_reg && data_ready_in) begin
      dv_next = 1'b0;
    end
    if (fo_pop) begin
      dv_next = 1'b1;
      dout_next = fo_data;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      dv_reg <= 1'b0;
      dout_reg <= FBH_BYTE_RST;
    end else begin
      dv_reg <= dv_next;
      dout_reg <= dout_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link control
  always_comb begin
    cmd_bytes = {cmd_reg.addr, cmd_reg.fetch_byte_count};
    cur_byte = cmd_bytes[(FBH_CMD_BYTES*FBH_BYTE_W-1) - 32'(idx_reg)*FBH_BYTE_W -: FBH_BYTE_W];
    // room for the byte being read: fifo not full and nothing waiting in the register stage
    room = fifo_wr_ready && !fifo_v_reg;
    state_next = state_reg;
    cmd_next = cmd_reg;
    idx_next = idx_reg;
    left_next = left_reg;
    txd_next = txd_reg;
    txw_next = 1'b0;
    rxr_next = 1'b0;
    cmd_rdy_next = 1'b0;
    init_next = init_reg;
    fifo_d_next = fifo_d_reg;
    fifo_v_next = fifo_v_reg && !fifo_wr_ready;
    // a strobe issued last cycle may have moved a flag; skip one cycle after it, except for the back-to-back reset reads in FBH_ST_RSTRD
    case (state_reg)
      FBH_ST_PURGE: begin
        if (!rxr_reg) begin
          if (!fetch_rxempty_in) begin
            rxr_next = 1'b1;
          end else begin
            state_next = FBH_ST_RSTRD;
            idx_next = '0;
          end
        end
      end
      FBH_ST_RSTRD: begin
        if (idx_reg == FBH_IDX_W'(FBH_RESET_READS)) begin
          state_next = FBH_ST_IDLE;
          init_next = 1'b1;
          cmd_rdy_next = 1'b1;
        end else begin
          rxr_next = 1'b1;
          idx_next = idx_reg + 1'b1;
        end
      end
      FBH_ST_IDLE: begin
        cmd_rdy_next = 1'b1;
        if (cmd_valid_in && cmd_rdy_reg) begin
          cmd_next = cmd_in;
          idx_next = '0;
          cmd_rdy_next = 1'b0;
          state_next = FBH_ST_SEND;
        end
      end
      FBH_ST_SEND: begin
        if (!txw_reg && !fetch_txfull_in) begin
          txw_next = 1'b1;
          txd_next = cur_byte;
          if (idx_reg == FBH_IDX_W'(FBH_CMD_BYTES - 1)) begin
            left_next = cmd_reg.fetch_byte_count;
            state_next = FBH_ST_RECV;
          end else begin
            idx_next = idx_reg + 1'b1;
          end
        end
      end
      FBH_ST_RECV: begin
        if (left_reg == '0) begin
          state_next = FBH_ST_IDLE;
          cmd_rdy_next = 1'b1;
        end else if (!rxr_reg && !fetch_rxempty_in && room) begin
          rxr_next = 1'b1;
          fifo_d_next = fetch_rxdata_in;
          fifo_v_next = 1'b1;
          left_next = left_reg - 1'b1;
        end
      end
      default: begin
        state_next = FBH_ST_PURGE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_reg <= FBH_ST_PURGE;
      cmd_reg <= '0;
      idx_reg <= '0;
      left_reg <= '0;
      txd_reg <= FBH_BYTE_RST;
      txw_reg <= 1'b0;
      rxr_reg <= 1'b0;
      cmd_rdy_reg <= 1'b0;
      init_reg <= 1'b0;
      fifo_d_reg <= FBH_BYTE_RST;
      fifo_v_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      idx_reg <= idx_next;
      left_reg <= left_next;
      txd_reg <= txd_next;
      txw_reg <= txw_next;
      rxr_reg <= rxr_next;
      cmd_rdy_reg <= cmd_rdy_next;
      init_reg <= init_next;
      fifo_d_reg <= fifo_d_next;
      fifo_v_reg <= fifo_v_next;
    end
  end

  assign fetch_txdata_out = txd_reg;
  assign fetch_txwrite_out = txw_reg;
  assign fetch_rxread_out = rxr_reg;
  assign cmd_ready_out = cmd_rdy_reg;
  assign init_done_out = init_reg;
  assign data_out = dout_reg;
  assign data_valid_out = dv_reg;
endmodule : fbh_fetch_port
`default_nettype wire

// [testbench/fbh_checker_sva.sv]
// fetch port link checker
`timescale 1ns/1ps
`default_nettype none
module fbh_checker (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_ready_out,
  input wire logic init_done_out,
  input wire logic fetch_txfull_in,
  input wire logic [7:0] fetch_txdata_out,
  input wire logic fetch_txwrite_out,
  input wire logic fetch_rxempty_in,
  input wire logic fetch_rxread_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  sequence reset_reads;
    !init_done_out && fetch_rxread_out ##1 fetch_rxread_out;
  endsequence
  sequence init_ends;
    !fetch_rxread_out ##[0:2] init_done_out;
  endsequence
  AST_TX_FULL: assert property (fetch_txwrite_out |-> !$past(fetch_txfull_in))
    else $error("write while full");
  AST_TX_GAP: assert property (fetch_txwrite_out |=> !fetch_txwrite_out)
    else $error("write strobe too long");
  AST_TX_HOLD: assert property (!fetch_txwrite_out |-> $stable(fetch_txdata_out))
    else $error("tx byte moved");
  AST_RX_EMPTY: assert property (fetch_rxread_out && $past(init_done_out) |-> !$past(fetch_rxempty_in))
    else $error("read while empty");
  AST_RX_GAP: assert property (fetch_rxread_out && init_done_out |=> !fetch_rxread_out)
    else $error("read strobe too long");
  AST_RESET_READS: assert property (reset_reads |=> init_ends)
    else $error("bad reset reads");
  AST_INIT_HOLD: assert property (init_done_out |=> init_done_out)
    else $error("init done fell");
  AST_CMD_TAKE: assert property (cmd_valid_in && cmd_ready_out |=> !cmd_ready_out [*6])
    else $error("ready too soon");
  AST_FIRST_WRITE: assert property (cmd_valid_in && cmd_ready_out && !fetch_txfull_in
    |-> ##[1:4] fetch_txwrite_out)
    else $error("command not sent");
endmodule : fbh_checker
`default_nettype wire

// [testbench/fbh_periph_model.sv]
// storage fetch bridge model with byte fifos
`timescale 1ns/1ps
`default_nettype none
module fbh_periph_model (
  input wire logic clk_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_write_in,
  output logic tx_full_out = 1'b0,
  input wire logic rx_read_in,
  output logic rx_empty_out = 1'b0,
  output logic [7:0] rx_data_out = 8'h5a
);
  // stale bytes left from before start, drained by the purge reads
  logic [7:0] rxq[$] = '{8'h5a, 8'h5a, 8'h5a};
  logic [47:0] cmd = '0;
  logic [31:0] addr = '0;
  int occ = 0;
  int ncmd = 0;
  int pend = 0;
  always @(posedge clk_in) begin
    if (tx_write_in) begin
      cmd = {cmd[39:0], tx_data_in};
      occ++;
      ncmd++;
      if (ncmd == 6) begin
        ncmd = 0;
        addr = cmd[47:16];
        pend = int'(cmd[15:0]);
      end
    end else if (occ > 0 && $urandom_range(1) == 1) occ--;
    if (rx_read_in) begin
      if (rxq.size() == 0) begin
        ncmd = 0;
        pend = 0;
        occ = 0;
      end else void'(rxq.pop_front());
    end else if (pend > 0 && $urandom_range(2) == 0) begin
      rxq.push_back(addr[7:0] ^ 8'ha5);
      addr++;
      pend--;
    end
    tx_full_out <= occ == 3;
    rx_empty_out <= rxq.size() == 0;
    rx_data_out <= (rxq.size() > 0) ? rxq[0] : ~rx_data_out;
  end
endmodule : fbh_periph_model
`default_nettype wire

// [testbench/test_fetch_byte_handshake_cmd.sv]
// testbench for the fetch byte handshake command port
`timescale 1ns/1ps
`default_nettype none
module test_fetch_byte_handshake_cmd;
  import fbh_pkg::*;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic cmd_valid_in = 1'b0;
  logic data_ready_in = 1'b0;
  fbh_cmd_t cmd_in = '0;
  logic cmd_ready_out, data_valid_out, init_done_out, txfull, txwrite, rxempty, rxread;
  logic [7:0] data_out, txdata, rxdata;
  logic [7:0] exp_q[$];
  int n_mismatch = 0;
  int cmp_count = 0;
  int i;
  always #50 clk_in = ~clk_in;
  fbh_fetch_port #(.FIFO_DEPTH(16)) dut (.clk_in(clk_in), .srst_in(srst_in),
    .cmd_in(cmd_in), .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out),
    .data_out(data_out), .data_valid_out(data_valid_out), .data_ready_in(data_ready_in),
    .init_done_out(init_done_out), .fetch_txfull_in(txfull), .fetch_txdata_out(txdata),
    .fetch_txwrite_out(txwrite), .fetch_rxempty_in(rxempty), .fetch_rxdata_in(rxdata),
    .fetch_rxread_out(rxread));
  fbh_periph_model peer (.clk_in(clk_in), .tx_data_in(txdata), .tx_write_in(txwrite),
    .tx_full_out(txfull), .rx_read_in(rxread), .rx_empty_out(rxempty),
    .rx_data_out(rxdata));
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic test_done;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task automatic wait_idle;
    int k;
    for (k = 0; k < 3000 && cmd_ready_out !== 1'b1; k++) @(negedge clk_in);
    chk("cmd_ready", cmd_ready_out, 1);
    chk("init_done", init_done_out, 1);
  endtask : wait_idle
  task automatic fetch(logic [31:0] a, logic [15:0] n);
    int k;
    wait_idle();
    for (k = 0; k < int'(n); k++) exp_q.push_back(8'(a + k) ^ 8'ha5);
    cmd_in = {a, n};
    cmd_valid_in = 1'b1;
    @(negedge clk_in);
    cmd_valid_in = 1'b0;
    chk("ready_drop", cmd_ready_out, 0);
  endtask : fetch
  task automatic drain;
    int k;
    wait_idle();
    for (k = 0; k < 1000 && exp_q.size() > 0; k++) @(negedge clk_in);
    chk("left", exp_q.size(), 0);
  endtask : drain
  always @(negedge clk_in) data_ready_in <= $urandom_range(3) != 0;
  always @(posedge clk_in) begin
    if (!srst_in && data_valid_out === 1'b1 && data_ready_in) begin
      if (exp_q.size() == 0) chk("extra", 1, 0);
      else chk("data_out", data_out, exp_q.pop_front());
    end
  end
  initial begin
    #2ms;
    n_mismatch++;
    test_done();
  end
  initial begin
    void'($urandom(44));
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    srst_in = 1'b0;
    chk("init_low", init_done_out, 0);
    fetch(32'h0000_0100, 16'h0003);
    fetch(32'hffff_fffe, 16'h0000);
    fetch(32'hffff_fff0, 16'h0014);
    for (i = 0; i < 4; i++) fetch($urandom, 16'($urandom_range(9)));
    drain();
    srst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    srst_in = 1'b0;
    chk("rst_ready", cmd_ready_out, 0);
    fetch(32'h1234_5678, 16'h0005);
    drain();
    test_done();
  end
endmodule : test_fetch_byte_handshake_cmd
bind fbh_fetch_port fbh_checker chk_i (.*);
`default_nettype wire
